// File: tsi_defines.svh
// Purpose: shared constants of the time slot interchange switch
// Assumes: included by the package and by the switch
// Notes:   offsets, field positions and timing counts

`ifndef TSI_DEFINES_SVH
`define TSI_DEFINES_SVH

// ---------------------------------------------------------------
// stream geometry
// ---------------------------------------------------------------
`define TSI_STREAMS       4
`define TSI_CHANS         32
`define TSI_BYTE_BITS     8
`define TSI_MEM_DEPTH     (`TSI_STREAMS * `TSI_CHANS)

// ---------------------------------------------------------------
// serial timing
// ---------------------------------------------------------------
`define TSI_SER_CLK_KHZ   4096
`define TSI_BIT_RATE_KBPS 2048
`define TSI_CLKS_PER_BIT  (`TSI_SER_CLK_KHZ / `TSI_BIT_RATE_KBPS)
`define TSI_IDLE_RUN      3'h4
`define TSI_TX_LEAD       5'h02

// ---------------------------------------------------------------
// processor address map and connection word fields
// ---------------------------------------------------------------
`define TSI_DM_SEL_BIT    7
`define TSI_CM_EN_BIT     8
`define TSI_CM_PROC_BIT   9
`define TSI_SRC_MSB       6

`endif

// File: tsi_pkg.sv
// Purpose: types shared by the switch and its helpers
// Assumes: tsi_defines.svh gives the geometry
// Notes:   no logic here

`include "tsi_defines.svh"

package tsi_pkg;

  typedef enum {TSI_IDLE, TSI_WR, TSI_CM, TSI_DM, TSI_CPU, TSI_CPUR} tsi_state_e;

  // one received time slot of all streams
  typedef struct packed {
    logic [4:0]                                      ch;
    logic [`TSI_STREAMS-1:0][`TSI_BYTE_BITS-1:0]     data;
  } tsi_rx_s;

  // one time slot to transmit on all streams
  typedef struct packed {
    logic [`TSI_STREAMS-1:0]                         en;
    logic [`TSI_STREAMS-1:0][`TSI_BYTE_BITS-1:0]     data;
  } tsi_tx_s;

  // processor pins as sampled
  typedef struct packed {
    logic       cs_n;
    logic       strb;
    logic       rwn;
    logic       ale;
    logic       mux;
    logic       split;
    logic [7:0] addr;
    logic [7:0] adl;
    logic [7:0] dh;
  } tsi_cpu_s;

endpackage

// File: tsi_mem.sv
// Purpose: simple dual port memory, registered read data
// Assumes: one clock, clock enable freezes both ports
// Notes:   contents are not reset

`timescale 1ns/1ps
`default_nettype none

module tsi_mem #(
  parameter int W  = 8,
  parameter int D  = 128,
  parameter int AW = 7
) (
  input  wire logic          clk,
  input  wire logic          ce,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);
  logic [W-1:0] mem [D];

  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
    if (ce && re) begin
      rdata <= mem[raddr];
    end
  end
endmodule

`default_nettype wire

// File: tsi_buf2.sv
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: push and pop on the same clock
// Notes:   out_data comes straight from the head register

`timescale 1ns/1ps
`default_nettype none

module tsi_buf2 #(
  parameter int W = 37
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  logic [1:0]   cnt_r;
  logic [W-1:0] d0_r, d1_r;
  wire          push = in_valid & in_ready;
  wire          pop  = out_valid & out_ready;

  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = d0_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 2'h0;
      d0_r  <= '0;
      d1_r  <= '0;
    end else if (ce) begin
      case ({push, pop})
        2'b10: begin
          if (cnt_r == 2'h0) d0_r <= in_data;
          else d1_r <= in_data;
          cnt_r <= cnt_r + 2'h1;
        end
        2'b01: begin
          d0_r  <= d1_r;
          cnt_r <= cnt_r - 2'h1;
        end
        2'b11: begin
          if (cnt_r == 2'h1) d0_r <= in_data;
          else begin
            d0_r <= d1_r;
            d1_r <= in_data;
          end
        end
        default: ;
      endcase
    end
  end

  a_buf_fill_count: assert property (@(posedge clk) disable iff (!nrst || !ce)
    push && !pop |=> cnt_r == $past(cnt_r) + 2'h1)
    else $error("buffer count did not rise on push");
  c_buf_full: cover property (@(posedge clk) disable iff (!nrst) cnt_r == 2'h2);
endmodule

`default_nettype wire

// File: tsi_switch_port_interface.sv
// Purpose: 128 x 128 channel time slot switch with processor port
// Assumes: ser_clk is the serial clock, sys_clk is much faster
// Notes:   processor pins are synchronised, accesses are sys_clk based
//
// What this block does
// - any of 128 input channels can feed any of 128 output channels
// - four serial input streams at 2.048 Mb/s are received
// - four serial output streams at 2.048 Mb/s, each can float
// - the outside supplies a 4.096 MHz clock; bits shift on it
// - frame pulse polarity is found automatically and followed
// - reset clears counters and registers and floats the serial, data bus and acknowledge outputs
// - a frame measurement input gives the offset of its rising edge within the frame
// - non-multiplexed mode takes the address from eight address pins
// - multiplexed strobe style: strobe high and chip select low
// - non-multiplexed: strobe low together with chip select
// - split-strobe mode drives all 16 data lines while read low
// - strobe styles: the read/write pin sets the bus direction
// - split-strobe mode: low data lines are inputs while write low
// - mode select high gives multiplexed, low non-multiplexed
// - chip select low is needed for every access
// - acknowledge low when done, driven high at cycle end, then released
// - multiplexed mode latches the address from the low data lines

`timescale 1ns/1ps
`default_nettype none
`include "tsi_defines.svh"

module tsi_switch_port_interface (
  input  wire logic                    sys_clk,
  input  wire logic                    nrst,
  input  wire logic                    clk_en,
  input  wire logic                    ser_clk,
  input  wire logic                    frame_sync_in,
  input  wire logic                    frame_measure_in,
  input  wire logic [3:0]              serial_in_streams,
  output logic      [3:0]              serial_out_streams,
  output logic      [3:0]              serial_out_oe,
  input  wire logic                    cs_n,
  input  wire logic                    strobe_or_read_n,
  input  wire logic                    rw_or_write_n,
  input  wire logic                    addr_latch_strobe,
  input  wire logic                    port_mux_select,
  input  wire logic                    split_strobe_mode,
  input  wire logic [7:0]              cpu_addr_lines,
  input  wire logic [7:0]              addr_data_low_in,
  output logic      [7:0]              addr_data_low_out,
  output logic                         addr_data_low_oe,
  input  wire logic [7:0]              data_high_byte_in,
  output logic      [7:0]              data_high_byte_out,
  output logic                         data_high_byte_oe,
  output logic                         transfer_ack_n_out,
  output logic                         transfer_ack_n_oe,
  output logic                         frame_fmt_gci,
  output logic      [8:0]              frame_offset,
  output logic                         slot_buf_ready,
  output tsi_pkg::tsi_tx_s             slot_tx_debug
);
  import tsi_pkg::*;

  // ---------------------------------------------------------------
  // link side: frame detection and counters
  // ---------------------------------------------------------------
  logic       lce1_r, lce2_r;
  logic       fs_q_r, idle_r, pulse_q_r, fe_q_r;
  logic [2:0] run_r, bit_r;
  logic       half_r;
  logic [4:0] ch_r;
  logic [8:0] meas_r;
  logic       meas_tgl_r, rx_tgl_r;
  logic       txt1_r, txt2_r, txt3_r;
  tsi_rx_s    rx_r;
  tsi_tx_s    tx_hold_r, tx_r;
  logic       tx_tgl_r;
  logic [3:0] txe_r;
  logic [3:0][7:0] rx_byte;

  wire pulse     = frame_sync_in != idle_r;
  wire fstart    = pulse & !pulse_q_r;
  wire half_last = half_r == 1'(`TSI_CLKS_PER_BIT - 1);
  wire slot_end  = half_last & (bit_r == 3'h7);
  wire tx_arrive = txt2_r ^ txt3_r;

  // clock enable crosses into the link domain as a level
  always_ff @(posedge ser_clk or negedge nrst) begin
    if (!nrst) begin
      lce1_r <= 1'b0;
      lce2_r <= 1'b0;
    end else begin
      lce1_r <= clk_en;
      lce2_r <= lce1_r;
    end
  end

  // idle level is whatever stays put; a short pulse never qualifies
  always_ff @(posedge ser_clk or negedge nrst) begin
    if (!nrst) begin
      fs_q_r    <= 1'b1;
      run_r     <= 3'h0;
      idle_r    <= 1'b1;
      pulse_q_r <= 1'b0;
    end else if (lce2_r) begin
      fs_q_r    <= frame_sync_in;
      pulse_q_r <= pulse;
      if (frame_sync_in != fs_q_r) run_r <= 3'h0;
      else if (run_r != `TSI_IDLE_RUN) run_r <= run_r + 3'h1;
      if (run_r == `TSI_IDLE_RUN) idle_r <= fs_q_r;
    end
  end

  always_ff @(posedge ser_clk or negedge nrst) begin
    if (!nrst) begin
      half_r <= 1'b0;
      bit_r  <= 3'h0;
      ch_r   <= 5'h00;
    end else if (lce2_r) begin
      if (fstart) begin
        half_r <= 1'b0;
        bit_r  <= 3'h0;
        ch_r   <= 5'h00;
      end else begin
        half_r <= ~half_r;
        if (half_last) bit_r <= bit_r + 3'h1;
        if (slot_end) ch_r <= ch_r + 5'h01;
      end
    end
  end

  // per stream shift registers, msb first
  for (genvar g = 0; g < `TSI_STREAMS; g++) begin : g_str
    logic [7:0] rx_sh_r, tx_sh_r;
    always_ff @(posedge ser_clk or negedge nrst) begin
      if (!nrst) begin
        rx_sh_r <= 8'h00;
        tx_sh_r <= 8'h00;
      end else if (lce2_r && half_last) begin
        rx_sh_r <= rx_byte[g];
        tx_sh_r <= slot_end ? tx_hold_r.data[g] : {tx_sh_r[6:0], 1'b0};
      end
    end
    assign rx_byte[g]            = {rx_sh_r[6:0], serial_in_streams[g]};
    assign serial_out_streams[g] = tx_sh_r[7];
    assign serial_out_oe[g]      = txe_r[g];
  end

  // slot hand-off: bundle is held a whole slot, toggle marks it
  always_ff @(posedge ser_clk or negedge nrst) begin
    if (!nrst) begin
      rx_r      <= '0;
      rx_tgl_r  <= 1'b0;
      txe_r     <= 4'h0;
      tx_hold_r <= '0;
      txt1_r    <= 1'b0;
      txt2_r    <= 1'b0;
      txt3_r    <= 1'b0;
    end else if (lce2_r) begin
      txt1_r <= tx_tgl_r;
      txt2_r <= txt1_r;
      txt3_r <= txt2_r;
      if (tx_arrive) tx_hold_r <= tx_r;
      if (slot_end) begin
        rx_r     <= '{ch: ch_r, data: rx_byte};
        rx_tgl_r <= ~rx_tgl_r;
        txe_r    <= tx_hold_r.en;
      end
    end
  end

  // offset of the measurement edge within the frame, in half bits
  always_ff @(posedge ser_clk or negedge nrst) begin
    if (!nrst) begin
      fe_q_r     <= 1'b0;
      meas_r     <= 9'h000;
      meas_tgl_r <= 1'b0;
    end else if (lce2_r) begin
      fe_q_r <= frame_measure_in;
      if (frame_measure_in && !fe_q_r) begin
        meas_r     <= {ch_r, bit_r, half_r};
        meas_tgl_r <= ~meas_tgl_r;
      end
    end
  end

  // ---------------------------------------------------------------
  // system side: processor pins and decode
  // ---------------------------------------------------------------
  tsi_cpu_s   cpu_in, cpu1_r, cpu2_r;
  logic [7:0] alat_r;

  assign cpu_in = '{cs_n: cs_n, strb: strobe_or_read_n, rwn: rw_or_write_n,
                    ale: addr_latch_strobe, mux: port_mux_select,
                    split: split_strobe_mode, addr: cpu_addr_lines,
                    adl: addr_data_low_in, dh: data_high_byte_in};

  // all ones means deselected, so reset never fakes an access
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cpu1_r <= '1;
      cpu2_r <= '1;
      alat_r <= 8'h00;
    end else if (clk_en) begin
      cpu1_r <= cpu_in;
      cpu2_r <= cpu1_r;
      if (cpu2_r.mux && cpu2_r.ale) alat_r <= cpu2_r.adl;
    end
  end

  wire       sel       = !cpu2_r.cs_n;
  wire       mmux_act  = cpu2_r.mux & !cpu2_r.split & sel & cpu2_r.strb;
  wire       nmux_act  = !cpu2_r.mux & sel & !cpu2_r.strb;
  wire       spl_rd    = cpu2_r.mux & cpu2_r.split & sel & !cpu2_r.strb;
  wire       spl_wr    = cpu2_r.mux & cpu2_r.split & sel & !cpu2_r.rwn;
  wire       strb_act  = mmux_act | nmux_act;
  wire       acc_act   = strb_act | spl_rd | spl_wr;
  wire       acc_wr    = strb_act ? !cpu2_r.rwn : spl_wr;
  wire [7:0] acc_addr  = cpu2_r.mux ? alat_r : cpu2_r.addr;
  wire       dm_sel    = acc_addr[`TSI_DM_SEL_BIT];

  // ---------------------------------------------------------------
  // system side: crossings, buffer, memories
  // ---------------------------------------------------------------
  logic       rxt1_r, rxt2_r, rxt3_r, mt1_r, mt2_r, mt3_r, g1_r, g2_r;
  tsi_rx_s    cur_r, buf_out;
  logic       buf_ov;
  tsi_state_e state_r, state_nxt;
  logic [1:0] idx_r;
  logic       taken_r, done_r, ack_hi_r;
  logic [15:0] rd_data_r, cm_rd;
  logic [7:0] dm_rd;

  wire rx_arrive = rxt2_r ^ rxt3_r;
  wire cpu_pend  = acc_act & !taken_r;
  wire buf_pop   = (state_r == TSI_IDLE) & !cpu_pend;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      {rxt1_r, rxt2_r, rxt3_r} <= 3'h0;
      {mt1_r, mt2_r, mt3_r}    <= 3'h0;
      {g1_r, g2_r}             <= 2'h0;
      frame_offset             <= 9'h000;
    end else if (clk_en) begin
      {rxt1_r, rxt2_r, rxt3_r} <= {rx_tgl_r, rxt1_r, rxt2_r};
      {mt1_r, mt2_r, mt3_r}    <= {meas_tgl_r, mt1_r, mt2_r};
      {g1_r, g2_r}             <= {~idle_r, g1_r};
      if (mt2_r ^ mt3_r) frame_offset <= meas_r;
    end
  end
  assign frame_fmt_gci = g2_r;

  // a stall by the memory engine parks up to two slots here
  tsi_buf2 #(.W($bits(tsi_rx_s))) u_buf (
    .clk       (sys_clk),
    .nrst      (nrst),
    .ce        (clk_en),
    .in_valid  (rx_arrive),
    .in_ready  (slot_buf_ready),
    .in_data   (rx_r),
    .out_valid (buf_ov),
    .out_ready (buf_pop),
    .out_data  (buf_out)
  );

  wire [6:0] slot_addr = {idx_r, cur_r.ch};
  wire [6:0] lead_addr = {idx_r, cur_r.ch + `TSI_TX_LEAD};
  wire       in_cpu    = state_r == TSI_CPU;
  wire       cm_we     = in_cpu & acc_wr & !dm_sel;
  wire       cm_re     = (state_r == TSI_WR) | in_cpu;
  wire [6:0] cm_raddr  = in_cpu ? acc_addr[6:0] : lead_addr;
  wire       dm_re     = (state_r == TSI_CM) | in_cpu;
  wire [6:0] dm_raddr  = in_cpu ? acc_addr[6:0] : cm_rd[`TSI_SRC_MSB:0];
  wire [7:0] tx_byte   = cm_rd[`TSI_CM_PROC_BIT] ? cm_rd[7:0] : dm_rd;

  // connection memory: source address, enable and processor bits
  tsi_mem #(.W(16), .D(`TSI_MEM_DEPTH), .AW(7)) u_cm (
    .clk   (sys_clk),
    .ce    (clk_en),
    .we    (cm_we),
    .waddr (acc_addr[6:0]),
    .wdata ({cpu2_r.dh, cpu2_r.adl}),
    .re    (cm_re),
    .raddr (cm_raddr),
    .rdata (cm_rd)
  );

  // data memory holds the last byte received in each slot
  tsi_mem #(.W(8), .D(`TSI_MEM_DEPTH), .AW(7)) u_dm (
    .clk   (sys_clk),
    .ce    (clk_en),
    .we    (state_r == TSI_WR),
    .waddr (slot_addr),
    .wdata (cur_r.data[idx_r]),
    .re    (dm_re),
    .raddr (dm_raddr),
    .rdata (dm_rd)
  );

  // ---------------------------------------------------------------
  // system side: slot engine and processor access
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      TSI_IDLE: begin
        if (cpu_pend) state_nxt = TSI_CPU;
        else if (buf_ov) state_nxt = TSI_WR;
      end
      TSI_WR:   state_nxt = TSI_CM;
      TSI_CM:   state_nxt = TSI_DM;
      TSI_DM:   state_nxt = (idx_r == 2'h3) ? TSI_IDLE : TSI_WR;
      TSI_CPU:  state_nxt = TSI_CPUR;
      TSI_CPUR: state_nxt = TSI_IDLE;
      default:  state_nxt = TSI_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r  <= TSI_IDLE;
      cur_r    <= '0;
      idx_r    <= 2'h0;
      tx_r     <= '0;
      tx_tgl_r <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      if (buf_pop && buf_ov) cur_r <= buf_out;
      if (state_r == TSI_DM) begin
        tx_r.data[idx_r] <= tx_byte;
        tx_r.en[idx_r]   <= cm_rd[`TSI_CM_EN_BIT];
        idx_r            <= idx_r + 2'h1;
        if (idx_r == 2'h3) tx_tgl_r <= ~tx_tgl_r;
      end
    end
  end
  assign slot_tx_debug = tx_r;

  // acknowledge: low once done, high for a cycle after, then floated
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      taken_r   <= 1'b0;
      done_r    <= 1'b0;
      ack_hi_r  <= 1'b0;
      rd_data_r <= 16'h0000;
    end else if (clk_en) begin
      taken_r  <= acc_act & (taken_r | in_cpu);
      done_r   <= acc_act & (done_r | (state_r == TSI_CPUR));
      ack_hi_r <= done_r & !acc_act;
      if (state_r == TSI_CPUR) rd_data_r <= dm_sel ? {8'h00, dm_rd} : cm_rd;
    end
  end

  assign transfer_ack_n_oe  = done_r | ack_hi_r;
  assign transfer_ack_n_out = !done_r;
  assign addr_data_low_oe   = acc_act & !acc_wr;
  assign data_high_byte_oe  = acc_act & !acc_wr;
  assign addr_data_low_out  = rd_data_r[7:0];
  assign data_high_byte_out = rd_data_r[15:8];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_bit_two_clks: assert property (
    @(posedge ser_clk) disable iff (!nrst)
    !$stable(bit_r) |-> $past(half_last) || $past(fstart))
    else $error("bit counter moved off a bit boundary");
  a_fmt_idle_low: assert property (
    @(posedge ser_clk) disable iff (!nrst || !lce2_r)
    (!frame_sync_in)[*7] |=> !idle_r)
    else $error("low idle frame sync not recognised");
  a_tx_float_reset: assert property (
    @(posedge ser_clk) !nrst |-> serial_out_oe == 4'h0)
    else $error("serial output driven in reset");
  a_dbus_float_reset: assert property (
    @(posedge sys_clk) !nrst |-> !addr_data_low_oe && !transfer_ack_n_oe)
    else $error("processor port driven in reset");
  a_ack_low_done: assert property (
    @(posedge sys_clk) disable iff (!nrst || !clk_en)
    $rose(acc_act) |-> ##[1:16] (transfer_ack_n_oe && !transfer_ack_n_out) || !acc_act)
    else $error("acknowledge not given");
  a_ack_high_release: assert property (
    @(posedge sys_clk) disable iff (!nrst || !clk_en)
    done_r && !acc_act |=> (transfer_ack_n_oe && transfer_ack_n_out) ##1 !transfer_ack_n_oe)
    else $error("acknowledge not driven high then released");
  a_read_data_dm: assert property (
    @(posedge sys_clk) disable iff (!nrst || !clk_en)
    state_r == TSI_CPUR && dm_sel |=> data_high_byte_out == 8'h00
      && addr_data_low_out == $past(dm_rd))
    else $error("read data not from data memory");
  a_write_low_input: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    spl_wr [*2] |-> !addr_data_low_oe && !data_high_byte_oe)
    else $error("data bus driven during write");
  a_nmux_addr_pins: assert property (
    @(posedge sys_clk) disable iff (!nrst || !clk_en)
    in_cpu && !cpu2_r.mux |-> cm_raddr == cpu2_r.addr[6:0])
    else $error("non-multiplexed address not taken from pins");

  c_cpu_read:   cover property (@(posedge sys_clk) state_r == TSI_CPUR && !acc_wr);
  c_cpu_write:  cover property (@(posedge sys_clk) cm_we);
  c_frame_seen: cover property (@(posedge ser_clk) fstart);
  c_slot_sent:  cover property (@(posedge sys_clk) state_r == TSI_DM && idx_r == 2'h3);
endmodule

`default_nettype wire

// File: tsi_tdm_src.sv
// Purpose: serial stream source with frame pulse and serial clock
// Assumes: frame pulse idle high unless fs_pol, byte of stream s slot c is {s, c, 1}
// Notes:   serial clock runs free, as on a real backplane
`timescale 1ns/1ps
`default_nettype none
module tsi_tdm_src (
  input  wire logic       fs_pol,
  output logic            ser_clk,
  output logic            frame_sync_in,
  output logic      [3:0] serial_in_streams
);
  logic [8:0] cnt_r = 9'h1f0;
  initial begin
    ser_clk = 1'b0;
  end
  always #6 ser_clk = ~ser_clk;
  // change on the falling edge so the device samples settled bits
  always @(negedge ser_clk) cnt_r <= cnt_r + 9'h001;
  assign frame_sync_in = (cnt_r != 9'h1ff) ^ fs_pol;
  always_comb begin
    logic [7:0] b;
    b = 8'h00;
    for (int s = 0; s < 4; s++) begin
      b = {s[1:0], cnt_r[8:4], 1'b1};
      serial_in_streams[s] = b[3'h7 - cnt_r[3:1]];
    end
  end
endmodule
`default_nettype wire

// File: tsi_switch_port_interface_test.sv
// Purpose: self-checking bench of the switch processor port and streams
// Assumes: stream source model drives the serial side
// Notes:   processor pins change at the falling edge of sys_clk, fe at the falling edge of ser_clk
`timescale 1ns/1ps
`default_nettype none
module tsi_switch_port_interface_test;
  import tsi_pkg::*;
  logic sys_clk = 1'b0, nrst = 1'b0, ser_clk, fsync, cs_n = 1'b1, strb = 1'b1, rwn = 1'b1;
  logic ale = 1'b0, mux = 1'b0, split = 1'b0, adl_oe, dh_oe, ack_out, ack_oe, gci, sbr;
  logic [3:0] rx, tx, tx_oe;
  logic [7:0] addr = 8'h00, adl_in = 8'h00, dh_in = 8'h00, adl_out, dh_out;
  logic [15:0] q;
  logic [8:0] fofs;
  logic [7:0] txw = 8'h00;
  logic fe = 1'b0, fpol = 1'b0;
  tsi_tx_s dbg;
  int fail_count = 0, samples_checked = 0, cyc = 0;
  always #2.5 sys_clk = ~sys_clk;
  tsi_tdm_src u_tsi_tdm_src (.fs_pol(fpol), .ser_clk(ser_clk), .frame_sync_in(fsync),
    .serial_in_streams(rx));
  // output bits are settled at even source counts; oe picks the slot
  always @(posedge ser_clk) begin
    if (tx_oe[1] === 1'b1 && !u_tsi_tdm_src.cnt_r[0]) txw <= {txw[6:0], tx[1]};
  end
  tsi_switch_port_interface u_tsi_switch_port_interface (
    .sys_clk(sys_clk), .nrst(nrst), .clk_en(1'b1), .ser_clk(ser_clk),
    .frame_sync_in(fsync), .frame_measure_in(fe), .serial_in_streams(rx),
    .serial_out_streams(tx), .serial_out_oe(tx_oe), .cs_n(cs_n),
    .strobe_or_read_n(strb), .rw_or_write_n(rwn), .addr_latch_strobe(ale),
    .port_mux_select(mux), .split_strobe_mode(split), .cpu_addr_lines(addr),
    .addr_data_low_in(adl_in), .addr_data_low_out(adl_out), .addr_data_low_oe(adl_oe),
    .data_high_byte_in(dh_in), .data_high_byte_out(dh_out), .data_high_byte_oe(dh_oe),
    .transfer_ack_n_out(ack_out), .transfer_ack_n_oe(ack_oe), .frame_fmt_gci(gci),
    .frame_offset(fofs), .slot_buf_ready(sbr), .slot_tx_debug(dbg));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  // m: 0 non-mux strobe, 1 mux strobe, 2 mux split strobes
  task automatic cpu(input int m, input logic wr, input logic [7:0] a, input logic [15:0] d);
    int n;
    @(negedge sys_clk);
    mux = (m != 0);
    split = (m == 2);
    addr = a;
    adl_in = mux ? a : d[7:0];
    dh_in = d[15:8];
    ale = mux;
    rwn = split | !wr;
    strb = !mux | split;
    @(negedge sys_clk);
    ale = 1'b0;
    adl_in = d[7:0];
    @(negedge sys_clk);
    cs_n = 1'b0;
    if (split && wr) rwn = 1'b0;
    else strb = mux & !split;
    n = 0;
    while (!(ack_oe === 1'b1 && ack_out === 1'b0) && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    chk(n < 40, 1'b1);
    chk({adl_oe, dh_oe}, {2{!wr}});
    q = {dh_out, adl_out};
    cs_n = 1'b1;
    rwn = 1'b1;
    strb = !mux | split;
    n = 0;
    while (ack_out !== 1'b1 && n < 10) begin
      @(negedge sys_clk);
      n++;
    end
    chk({ack_oe, n < 10}, 2'b11);
    @(negedge sys_clk);
    chk({ack_oe, adl_oe, dh_oe}, 3'b000);
  endtask
  task automatic t_reset();
    chk({tx_oe, adl_oe, dh_oe, ack_oe, ack_out}, 8'h01);
  endtask
  task automatic t_modes();
    for (int m = 0; m < 3; m++) begin
      cpu(m, 1'b1, 8'h20 + m[7:0], 16'h0100 + m[15:0]);
      cpu((m + 1) % 3, 1'b0, 8'h20 + m[7:0], 16'h0000);
      chk(q, 16'h0100 + m[15:0]);
    end
  endtask
  task automatic t_no_select();
    @(negedge sys_clk);
    mux = 1'b0;
    strb = 1'b0;
    repeat (12) @(negedge sys_clk);
    chk({ack_oe, adl_oe}, 2'b00);
    strb = 1'b1;
  endtask
  task automatic t_switch();
    logic seen_oe;
    logic full;
    logic seen_dbg;
    seen_oe = 1'b0;
    full = 1'b0;
    seen_dbg = 1'b0;
    cpu(0, 1'b1, 8'h23, 16'h0145);
    cpu(1, 1'b1, 8'hc5, 16'h0000);
    repeat (2600) begin
      @(negedge sys_clk);
      seen_oe |= (tx_oe[1] === 1'b1);
      full |= (sbr !== 1'b1);
      seen_dbg |= (dbg.en[1] === 1'b1 && dbg.data[1] === 8'h8b);
    end
    chk({seen_oe, seen_dbg, full, gci}, 4'b1100);
    @(negedge fsync);
    repeat (80) @(negedge ser_clk);
    chk(txw, 8'h8b);
    cpu(0, 1'b0, 8'hc5, 16'h0000);
    chk(q, 16'h008b);
    cpu(2, 1'b0, 8'hff, 16'h0000);
    chk(q, 16'h00ff);
    cpu(1, 1'b0, 8'h80, 16'h0000);
    chk(q, 16'h0001);
  endtask
  task automatic t_measure();
    @(negedge fsync);
    repeat (167) @(negedge ser_clk);
    fe = 1'b1;
    @(negedge ser_clk);
    fe = 1'b0;
    repeat (10) @(negedge sys_clk);
    chk(fofs, 9'h0a6);
  endtask
  task automatic t_gci();
    fpol = 1'b1;
    repeat (60) @(negedge sys_clk);
    chk(gci, 1'b1);
    fpol = 1'b0;
    repeat (60) @(negedge sys_clk);
    chk(gci, 1'b0);
  endtask
  task automatic give_verdict();
    if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ceiling well above the four to five frames of traffic plus port accesses
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (2) @(negedge sys_clk);
    t_reset();
    nrst = 1'b1;
    t_modes();
    t_no_select();
    t_switch();
    t_measure();
    t_gci();
    give_verdict();
  end
endmodule
`default_nettype wire
